// >>> common/asr_consts.svh
// register map, field positions, reset values and tick counts of the serial block
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

// register byte offsets, one aligned word each
`define ASR_OFS_CTRL1     8'h00
`define ASR_OFS_CTRL2     8'h04
`define ASR_OFS_CTRL3     8'h08
`define ASR_OFS_STAT1     8'h0c
`define ASR_OFS_DATA      8'h10
`define ASR_OFS_BAUD      8'h14
`define ASR_OFS_ISTAT     8'h18
`define ASR_OFS_IMASK     8'h1c

// serial_control_one fields
`define ASR_C1_ENABLE     6
`define ASR_C1_INVERT     5
`define ASR_C1_NINE       4
`define ASR_C1_WMASK      8'h70
// serial_control_two fields
`define ASR_C2_TXE_IE     7
`define ASR_C2_DONE_IE    6
`define ASR_C2_RXF_IE     5
`define ASR_C2_TX_EN      3
`define ASR_C2_RX_EN      2
`define ASR_C2_WMASK      8'hec
// control three fields
`define ASR_C3_RX_B8      7
`define ASR_C3_TX_B8      6
// serial_status_one fields
`define ASR_S1_TXE        7
`define ASR_S1_DONE       6
`define ASR_S1_RXF        5
`define ASR_S1_NOISE      2
`define ASR_S1_FRM        1
// interrupt status and mask layout
`define ASR_IRQ_RXF       0
`define ASR_IRQ_TXE       1
`define ASR_IRQ_DONE      2
`define ASR_IRQ_FRM       3
`define ASR_IRQ_NOISE     4

// baud divisor reset: tick period is divisor plus one clock
`define ASR_BAUD_RST      16'h006b

// oversample tick positions within a bit, counted from one
`define ASR_OS_FIRST      5'h01
`define ASR_OS_S3         5'h03
`define ASR_OS_S5         5'h05
`define ASR_OS_S7         5'h07
`define ASR_OS_S8         5'h08
`define ASR_OS_S9         5'h09
`define ASR_OS_S10        5'h0a
`define ASR_OS_LATE_MIN   5'h0b
`define ASR_OS_LAST       5'h10
`define ASR_OS_EARLY_MIN  5'h02
`define ASR_OS_EARLY_MAX  5'h07
// last data bit index per length
`define ASR_LAST_BIT8     4'h7
`define ASR_LAST_BIT9     4'h8
// ticks from start edge to last stop sample
`define ASR_STOP8_TICKS   8'h9a
`define ASR_STOP9_TICKS   8'haa
// transmit frame lengths in bits and last tick index within a bit
`define ASR_TX_BITS8      4'ha
`define ASR_TX_BITS9      4'hb
`define ASR_TX_TICK_LAST  4'hf

`endif

// >>> common/asr_pkg.sv
// types and helpers shared by the serial block
package asr_pkg;

  // receiver states, gray along idle-start-data-stop
  typedef enum logic [1:0] {
    ASR_RX_IDLE  = 2'b00,
    ASR_RX_START = 2'b01,
    ASR_RX_DATA  = 2'b11,
    ASR_RX_STOP  = 2'b10
  } asr_rx_state_e;

  // tick divider state
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } asr_tick_s;

  // transmitter state
  typedef struct packed {
    logic        busy;
    logic        taken;
    logic        out;
    logic [3:0]  tcnt;
    logic [3:0]  bits;
    logic [10:0] sh;
  } asr_tx_s;

  // top level state: bus, registers, receiver
  typedef struct packed {
    logic          wreq;
    logic [31:0]   rdata;
    logic          irq;
    logic [7:0]    c1;
    logic [7:0]    c2;
    logic          tx_b8;
    logic [15:0]   baud;
    logic [7:0]    tx_buf;
    logic          tx_buf_b8;
    logic          buf_full;
    logic [7:0]    rx_data;
    logic          rx_b8;
    logic          txe;
    logic          done;
    logic          rxf;
    logic          frm;
    logic          noise;
    logic [4:0]    ist;
    logic [4:0]    imask;
    logic          sync1;
    logic          sync2;
    asr_rx_state_e st;
    logic [2:0]    hist;
    logic [4:0]    os_cnt;
    logic [1:0]    sv;
    logic [1:0]    dv;
    logic [3:0]    bidx;
    logic [8:0]    sh;
    logic          nacc;
    logic          armed;
    logic [7:0]    hcnt;
    logic          resyn;
  } asr_top_s;

  // two of three vote
  function automatic logic asr_maj(input logic [2:0] v);
    asr_maj = (v[2] & v[1]) | (v[2] & v[0]) | (v[1] & v[0]);
  endfunction : asr_maj

endpackage : asr_pkg

// >>> hw/asr_tick_gen.sv
// oversample tick divider: one-cycle enable at sixteen times the baud rate
`timescale 1ns/100ps
`include "asr_consts.svh"
module asr_tick_gen
  import asr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] divisor,
  output logic             tick
);

  asr_tick_s r_reg;   // divider state
  asr_tick_s r_next;  // next divider state

  // count up to the divisor, pulse at wrap
  always_comb begin
    r_next      = r_reg;
    r_next.tick = 1'b0;
    if (r_reg.cnt >= divisor) begin
      r_next.cnt  = 16'h0000;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + 16'h0001;
    end
  end

  // register the divider
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick;

  a_tick_single : assert property (@(posedge mclk) disable iff (sys_rst)
    tick && divisor != 16'h0000 |=> !tick)
    else $error("oversample tick lasted more than one cycle");

endmodule : asr_tick_gen

// >>> hw/asr_tx.sv
// transmit shift register with start and stop framing and polarity control
`timescale 1ns/100ps
`include "asr_consts.svh"
module asr_tx
  import asr_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       tick,
  input  wire logic       req,
  input  wire logic [8:0] data,
  input  wire logic       nine,
  input  wire logic       invert,
  output logic            serial_out,
  output logic            taken,
  output logic            busy
);

  asr_tx_s r_reg;   // transmitter state
  asr_tx_s r_next;  // next transmitter state

  // load from the buffer when idle, shift one bit per sixteen ticks
  always_comb begin
    logic level;
    level        = r_reg.busy ? r_reg.sh[0] : 1'b1;  // idle line is one
    r_next       = r_reg;
    r_next.taken = 1'b0;
    r_next.out   = invert ^ level;
    if (!r_reg.busy) begin
      if (req) begin
        r_next.busy  = 1'b1;
        r_next.taken = 1'b1;
        r_next.tcnt  = 4'h0;
        r_next.sh    = nine ? {1'b1, data, 1'b0} : {2'b11, data[7:0], 1'b0};
        r_next.bits  = nine ? `ASR_TX_BITS9 : `ASR_TX_BITS8;
      end
    end else if (tick) begin
      r_next.tcnt = r_reg.tcnt + 4'h1;
      if (r_reg.tcnt == `ASR_TX_TICK_LAST) begin
        r_next.sh   = {1'b1, r_reg.sh[10:1]};
        r_next.bits = r_reg.bits - 4'h1;
        if (r_reg.bits == 4'h1) begin
          r_next.busy = 1'b0;  // frame done
        end
      end
    end
  end

  // register the transmitter; reset drives the line high
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_reg     <= '0;
      r_reg.out <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign serial_out = r_reg.out;
  assign taken      = r_reg.taken;
  assign busy       = r_reg.busy;

  a_tx_idle_pol : assert property (@(posedge mclk) disable iff (sys_rst)
    $past(!r_reg.busy) |-> serial_out == !$past(invert))
    else $error("idle line level does not follow polarity setting");

endmodule : asr_tx

// >>> hw/asr_serial_top.sv
// serial block top: avalon slave, registers, interrupts and receive data recovery
// Summary of operation
// - invert every transmitted level when polarity set
// - empty flag on buffer handoff, enable gates interrupt
// - done flag: shifter and buffer both empty
// - ninth bit stored; eight-bit mode copies bit seven
// - full character moves to buffer, sets full
// - sample input on tick at sixteen times baud
// - resync after start and after one-to-zero change
// - start search: zero after three ones
// - start verify ticks three five seven, noise
// - failed verify resets counter, restarts search
// - data bit is majority of eight nine ten
// - late start samples only flag noise
// - stop majority zero sets framing error
// - framing error set together with full flag
// - resync on valid falling edge within character
// - stop sampled nine or ten bits plus ten
// - one stray stop sample noise, two framing
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`include "asr_consts.svh"
module asr_serial_top
  import asr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             irq
);

  asr_top_s    r_reg;      // all block state
  asr_top_s    r_next;     // next block state
  logic        tick;       // oversample enable
  logic        tx_taken;   // buffer handed to shifter
  logic        tx_busy;    // shifter active
  logic        tx_req;     // buffer waits for shifter
  logic        nine;       // nine-bit characters
  logic        rx_on;      // receiver enabled
  logic        sample;     // synchronised input level
  logic        vote;       // majority of the three mid samples
  logic        disagree;   // mid samples not all equal
  logic        acc;        // bus request completes this edge
  logic        wr_data;    // completing write to data register
  logic [7:0]  addr_w;     // word-aligned address

  assign nine     = r_reg.c1[`ASR_C1_NINE];
  assign rx_on    = r_reg.c1[`ASR_C1_ENABLE] & r_reg.c2[`ASR_C2_RX_EN];
  assign tx_req   = r_reg.buf_full & r_reg.c1[`ASR_C1_ENABLE] & r_reg.c2[`ASR_C2_TX_EN];
  assign sample   = r_reg.sync2;
  assign vote     = asr_maj({r_reg.dv, sample});
  assign disagree = (|{r_reg.dv, sample}) & ~(&{r_reg.dv, sample});
  assign acc      = (avs_read | avs_write) & ~r_reg.wreq;
  assign addr_w   = {avs_address[7:2], 2'b00};
  assign wr_data  = acc & avs_write & avs_byteenable[0] & (addr_w == `ASR_OFS_DATA);

  // oversample tick source
  asr_tick_gen u_tick (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .divisor (r_reg.baud),
    .tick    (tick)
  );

  // transmit shifter
  asr_tx u_tx (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .tick       (tick),
    .req        (tx_req),
    .data       ({r_reg.tx_buf_b8, r_reg.tx_buf}),
    .nine       (nine),
    .invert     (r_reg.c1[`ASR_C1_INVERT]),
    .serial_out (serial_out_pin),
    .taken      (tx_taken),
    .busy       (tx_busy)
  );

  // bus, registers, flags and receiver in one next-state process
  always_comb begin
    logic [31:0] wmask;
    logic [31:0] rd;
    logic [4:0]  iset;
    logic [4:0]  ien;
    logic        post;
    logic        early;
    logic        late;
    logic        adv;
    wmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    rd     = 32'h0000_0000;
    iset   = 5'h00;
    post   = 1'b0;
    early  = 1'b0;
    late   = 1'b0;
    adv    = 1'b0;
    ien    = 5'h1f;
    r_next = r_reg;

    // readback mux, unmapped reads as zero
    unique case (addr_w)
      `ASR_OFS_CTRL1: rd[7:0] = r_reg.c1;
      `ASR_OFS_CTRL2: rd[7:0] = r_reg.c2;
      `ASR_OFS_CTRL3: begin
        rd[`ASR_C3_RX_B8] = r_reg.rx_b8;
        rd[`ASR_C3_TX_B8] = r_reg.tx_b8;
      end
      `ASR_OFS_STAT1: begin
        rd[`ASR_S1_TXE]   = r_reg.txe;
        rd[`ASR_S1_DONE]  = r_reg.done;
        rd[`ASR_S1_RXF]   = r_reg.rxf;
        rd[`ASR_S1_NOISE] = r_reg.noise;
        rd[`ASR_S1_FRM]   = r_reg.frm;
      end
      `ASR_OFS_DATA:  rd[7:0] = r_reg.rx_data;
      `ASR_OFS_BAUD:  rd[15:0] = r_reg.baud;
      `ASR_OFS_ISTAT: rd[4:0] = r_reg.ist;
      `ASR_OFS_IMASK: rd[4:0] = r_reg.imask;
      default:        rd = 32'h0000_0000;
    endcase

    // wait one cycle, then answer; read data captured in the wait cycle
    r_next.wreq = ~((avs_read | avs_write) & r_reg.wreq);
    if (avs_read & r_reg.wreq) begin
      r_next.rdata = rd;
    end

    // buffer handoff to shifter
    if (tx_taken) begin
      r_next.buf_full = 1'b0;
      r_next.txe      = 1'b1;
      iset[`ASR_IRQ_TXE] = 1'b1;
    end

    // register writes on the completing edge
    if (acc & avs_write) begin
      unique case (addr_w)
        `ASR_OFS_CTRL1: r_next.c1 = (r_reg.c1 & ~(wmask[7:0] & `ASR_C1_WMASK))
                                    | (avs_writedata[7:0] & wmask[7:0] & `ASR_C1_WMASK);
        `ASR_OFS_CTRL2: r_next.c2 = (r_reg.c2 & ~(wmask[7:0] & `ASR_C2_WMASK))
                                    | (avs_writedata[7:0] & wmask[7:0] & `ASR_C2_WMASK);
        `ASR_OFS_CTRL3: if (avs_byteenable[0]) begin
          r_next.tx_b8 = avs_writedata[`ASR_C3_TX_B8];
        end
        `ASR_OFS_BAUD:  r_next.baud = (r_reg.baud & ~wmask[15:0])
                                      | (avs_writedata[15:0] & wmask[15:0]);
        `ASR_OFS_IMASK: if (avs_byteenable[0]) begin
          r_next.imask = avs_writedata[4:0];
        end
        default: ;  // data handled below, others ignored
      endcase
    end
    if (wr_data) begin
      r_next.tx_buf    = avs_writedata[7:0];
      r_next.tx_buf_b8 = r_reg.tx_b8;
      r_next.buf_full  = 1'b1;
      r_next.txe       = 1'b0;
      r_next.done      = 1'b0;
    end

    // done flag: nothing buffered and shifter idle
    r_next.done = ~tx_busy & ~r_next.buf_full;
    iset[`ASR_IRQ_DONE] = r_next.done & ~r_reg.done;

    // read side effects: data read clears receive flags, interrupt status read clears what it showed
    if (acc & avs_read & (addr_w == `ASR_OFS_DATA)) begin
      r_next.rxf   = 1'b0;
      r_next.frm   = 1'b0;
      r_next.noise = 1'b0;
    end
    if (acc & avs_read & (addr_w == `ASR_OFS_ISTAT)) begin
      r_next.ist = r_reg.ist & ~r_reg.rdata[4:0];
    end

    // input synchroniser
    r_next.sync1 = serial_in_pin;
    r_next.sync2 = r_reg.sync1;

    // receive data recovery on each oversample tick
    if (!rx_on) begin
      r_next.st   = ASR_RX_IDLE;
      r_next.hist = 3'b000;
    end else if (tick) begin
      r_next.hist = {r_reg.hist[1:0], sample};
      if (r_reg.st == ASR_RX_IDLE) begin
        // start search: zero after three ones
        if (r_reg.hist == 3'b111 && !sample) begin
          r_next.st     = ASR_RX_START;
          r_next.os_cnt = `ASR_OS_FIRST;
          r_next.nacc   = 1'b0;
          r_next.armed  = 1'b0;
          r_next.hcnt   = 8'h01;
          r_next.resyn  = 1'b0;
        end
      end else begin
        r_next.hcnt   = r_reg.hcnt + 8'h01;
        r_next.os_cnt = r_reg.os_cnt + 5'h01;
        // falling edge after a one bit realigns the count
        if (r_reg.armed && r_reg.hist[0] && !sample && r_reg.st == ASR_RX_DATA) begin
          early = (r_reg.os_cnt >= `ASR_OS_LATE_MIN);
          late  = (r_reg.os_cnt >= `ASR_OS_EARLY_MIN) && (r_reg.os_cnt <= `ASR_OS_EARLY_MAX);
        end
        if (early | late) begin
          r_next.armed  = 1'b0;
          r_next.resyn  = 1'b1;
          r_next.os_cnt = `ASR_OS_FIRST;
        end
        adv = early | (r_reg.os_cnt == `ASR_OS_LAST);
        if (adv) begin
          r_next.os_cnt = `ASR_OS_FIRST;
        end
        unique case (r_reg.st)
          ASR_RX_START: begin
            if (r_reg.os_cnt == `ASR_OS_S3) begin
              r_next.sv[1] = sample;
            end
            if (r_reg.os_cnt == `ASR_OS_S5) begin
              r_next.sv[0] = sample;
            end
            if (r_reg.os_cnt == `ASR_OS_S7) begin
              if (asr_maj({r_reg.sv, sample})) begin
                r_next.st     = ASR_RX_IDLE;
                r_next.os_cnt = 5'h00;
                r_next.hist   = 3'b000;
              end else if (|{r_reg.sv, sample}) begin
                r_next.nacc = 1'b1;
              end
            end
            // late start samples only mark noise
            if (r_reg.os_cnt >= `ASR_OS_S8 && r_reg.os_cnt <= `ASR_OS_S10 && sample) begin
              r_next.nacc = 1'b1;
            end
            if (adv) begin
              r_next.st   = ASR_RX_DATA;
              r_next.bidx = 4'h0;
            end
          end
          ASR_RX_DATA: begin
            if (r_reg.os_cnt == `ASR_OS_S8) begin
              r_next.dv[1] = sample;
            end
            if (r_reg.os_cnt == `ASR_OS_S9) begin
              r_next.dv[0] = sample;
            end
            if (r_reg.os_cnt == `ASR_OS_S10) begin
              r_next.sh    = {vote, r_reg.sh[8:1]};
              r_next.armed = vote;
              if (disagree) begin
                r_next.nacc = 1'b1;
              end
            end
            if (adv) begin
              if (r_reg.bidx == (nine ? `ASR_LAST_BIT9 : `ASR_LAST_BIT8)) begin
                r_next.st = ASR_RX_STOP;
              end else begin
                r_next.bidx = r_reg.bidx + 4'h1;
              end
            end
          end
          ASR_RX_STOP: begin
            if (r_reg.os_cnt == `ASR_OS_S8) begin
              r_next.dv[1] = sample;
            end
            if (r_reg.os_cnt == `ASR_OS_S9) begin
              r_next.dv[0] = sample;
            end
            if (r_reg.os_cnt == `ASR_OS_S10) begin
              post        = 1'b1;
              r_next.st   = ASR_RX_IDLE;
              r_next.hist = 3'b000;
            end
          end
          ASR_RX_IDLE: ;  // handled above
        endcase
      end
    end

    // post a finished character; set wins over read clears
    if (post) begin
      r_next.rx_data = nine ? r_reg.sh[7:0] : r_reg.sh[8:1];
      r_next.rx_b8   = r_reg.sh[8];
      r_next.rxf     = 1'b1;
      iset[`ASR_IRQ_RXF] = 1'b1;
      if (!vote) begin
        r_next.frm = 1'b1;
        iset[`ASR_IRQ_FRM] = 1'b1;
      end
      if (r_reg.nacc | disagree) begin
        r_next.noise = 1'b1;
        iset[`ASR_IRQ_NOISE] = 1'b1;
      end
    end

    // sticky interrupt status, masked and enabled onto one line
    r_next.ist = r_next.ist | iset;
    ien[`ASR_IRQ_TXE]  = r_reg.c2[`ASR_C2_TXE_IE];
    ien[`ASR_IRQ_DONE] = r_reg.c2[`ASR_C2_DONE_IE];
    ien[`ASR_IRQ_RXF]  = r_reg.c2[`ASR_C2_RXF_IE];
    r_next.irq = |(r_next.ist & r_reg.imask & ien);
  end

  // register all state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_reg      <= '0;
      r_reg.wreq <= 1'b1;
      r_reg.txe  <= 1'b1;
      r_reg.done <= 1'b1;
      r_reg.baud <= `ASR_BAUD_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign avs_readdata    = r_reg.rdata;
  assign avs_waitrequest = r_reg.wreq;
  assign irq             = r_reg.irq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_edge;
    rx_on && tick && r_reg.st == ASR_RX_IDLE && r_reg.hist == 3'b111 && !sample;
  endsequence
  sequence s_verify;
    rx_on && tick && r_reg.st == ASR_RX_START && r_reg.os_cnt == `ASR_OS_S7;
  endsequence
  sequence s_stop;
    rx_on && tick && r_reg.st == ASR_RX_STOP && r_reg.os_cnt == `ASR_OS_S10;
  endsequence

  a_search_edge : assert property (s_edge |=> r_reg.st == ASR_RX_START
    && r_reg.os_cnt == `ASR_OS_FIRST)
    else $error("start edge did not begin a count");
  a_start_fail : assert property (s_verify ##0 ($countones({r_reg.sv, sample}) >= 2)
    |=> r_reg.st == ASR_RX_IDLE && r_reg.hist == 3'b000)
    else $error("failed start verification did not restart search");
  a_start_noise : assert property (s_verify ##0 ($countones({r_reg.sv, sample}) == 1)
    |=> r_reg.nacc && r_reg.st == ASR_RX_START)
    else $error("noisy start not flagged");
  a_start_kept : assert property (rx_on && tick && r_reg.st == ASR_RX_START
    && r_reg.os_cnt == `ASR_OS_S10 && sample |=> r_reg.nacc && r_reg.st == ASR_RX_START)
    else $error("late start sample cancelled start");
  a_data_vote : assert property (rx_on && tick && r_reg.st == ASR_RX_DATA
    && r_reg.os_cnt == `ASR_OS_S10 |=> r_reg.sh[8] == $past(vote))
    else $error("data bit not the majority");
  a_stop_frame : assert property (s_stop ##0 !vote |=> r_reg.rxf && r_reg.frm)
    else $error("zero stop majority without framing error");
  a_frame_full : assert property ($rose(r_reg.frm) |-> $rose(r_reg.rxf) || r_reg.rxf)
    else $error("framing error without full flag");
  a_stop_time : assert property (s_stop ##0 !r_reg.resyn |->
    r_reg.hcnt == (nine ? `ASR_STOP9_TICKS : `ASR_STOP8_TICKS))
    else $error("stop sampled at wrong tick count");
  a_empty_set : assert property (tx_taken && !wr_data |=> r_reg.txe)
    else $error("handoff did not set empty flag");
  a_done_meaning : assert property (r_reg.done |-> !r_reg.buf_full && !$past(tx_busy))
    else $error("done flag while data pending");

endmodule : asr_serial_top

// >>> verif/asr_remote_peer.sv
// remote serial partner: frame driver on the receive pin, decoder on the send pin
`timescale 1ns/100ps
module asr_remote_peer #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic mclk,
  input  wire logic line_in,
  output logic      line_out
);
  // mark level while idle
  initial line_out = 1'b1;

  // start, data lsb first, stop; glitch hits one middle sample of bit two
  task automatic send_char(input logic [8:0] d, input logic nine, input logic stp,
                           input logic glitch);
    logic [10:0] f;
    f = nine ? {stp, d, 1'b0} : {1'b0, stp, d[7:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(posedge mclk);
        line_out <= f[i] ^ (glitch && i == 2 && (c == 16 || c == 17));
      end
    end
    @(posedge mclk);
    line_out <= 1'b1;
  endtask : send_char

  // waits for a start level, then samples each bit at its centre
  task automatic recv_char(input logic inv, output logic [8:0] d, output logic ok);
    ok = 1'b0;
    for (int w = 0; w < 4000 && !ok; w++) begin
      @(posedge mclk);
      ok = ((line_in ^ inv) === 1'b0);
    end
    repeat (BIT_CLKS / 2) @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge mclk);
      d[i] = line_in ^ inv;
    end
  endtask : recv_char
endmodule : asr_remote_peer

// >>> verif/test_asr_serial_top.sv
// self-checking bench of the serial block
`timescale 1ns/100ps
`include "asr_consts.svh"
module test_asr_serial_top
  import asr_pkg::*;
;
  logic        mclk;
  logic        sys_rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        serial_in_pin;
  logic        serial_out_pin;
  logic        irq;
  int          num_errors = 0;  // mismatches seen
  int          cmp_count = 0;   // comparisons made
  logic [8:0]  rx_d;            // character decoded by the partner
  logic        rx_ok;           // partner found a start level

  // device under test
  asr_serial_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .irq(irq));

  // far side: divisor one gives a tick every two clocks, 32 clocks a bit
  asr_remote_peer #(.BIT_CLKS(32)) peer_u (.mclk(mclk), .line_in(serial_out_pin),
    .line_out(serial_in_pin));

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // compares one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // one avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      final_report();
    end
  endtask : bus

  // register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  // masked register read and compare
  task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & msk, exp, "register");
  endtask : rd

  // reset values, unmapped place, setup of an eight-bit link
  task automatic s_reset();
    rd(`ASR_OFS_STAT1, 32'hffffffff, 32'hc0);
    rd(`ASR_OFS_BAUD, 32'hffffffff, 32'h6b);
    rd(8'h40, 32'hffffffff, 32'h0);
    chk(serial_out_pin, 1, "idle");
    wr(`ASR_OFS_BAUD, 32'h1);
    wr(`ASR_OFS_CTRL1, 32'h40);
    wr(`ASR_OFS_CTRL2, 32'h2c);
    wr(`ASR_OFS_IMASK, 32'h1);
  endtask : s_reset

  // clean character: flags, bit eight copy, interrupt raised and cleared
  task automatic s_rx();
    peer_u.send_char(9'h0a5, 1'b0, 1'b1, 1'b0);
    chk(irq, 1, "irq");
    rd(`ASR_OFS_STAT1, 32'he6, 32'he0);
    rd(`ASR_OFS_CTRL3, 32'h80, 32'h80);
    rd(`ASR_OFS_DATA, 32'hff, 32'ha5);
    rd(`ASR_OFS_ISTAT, 32'h1f, 32'h01);
    repeat (2) @(posedge mclk);
    chk(irq, 0, "irq clear");
  endtask : s_rx

  // one noisy middle sample, then a character without stop bit
  task automatic s_rx_err();
    peer_u.send_char(9'h0a5, 1'b0, 1'b1, 1'b1);
    rd(`ASR_OFS_STAT1, 32'he6, 32'he4);
    rd(`ASR_OFS_DATA, 32'hff, 32'ha5);
    peer_u.send_char(9'h000, 1'b0, 1'b0, 1'b0);
    rd(`ASR_OFS_STAT1, 32'he6, 32'he2);
    rd(`ASR_OFS_DATA, 32'hff, 32'h00);
    rd(`ASR_OFS_ISTAT, 32'h1f, 32'h19);
  endtask : s_rx_err

  // nine-bit character whose ninth bit differs from bit seven
  task automatic s_nine();
    wr(`ASR_OFS_CTRL1, 32'h50);
    peer_u.send_char(9'h100, 1'b1, 1'b1, 1'b0);
    rd(`ASR_OFS_STAT1, 32'he6, 32'he0);
    rd(`ASR_OFS_CTRL3, 32'h80, 32'h80);
    rd(`ASR_OFS_DATA, 32'hff, 32'h00);
    rd(`ASR_OFS_ISTAT, 32'h1f, 32'h01);
  endtask : s_nine

  // inverted transmission, empty and done events with their enables off
  task automatic s_tx();
    wr(`ASR_OFS_IMASK, 32'h7);
    wr(`ASR_OFS_CTRL1, 32'h60);
    repeat (2) @(posedge mclk);
    chk(serial_out_pin, 0, "inverted idle");
    wr(`ASR_OFS_DATA, 32'h3c);
    peer_u.recv_char(1'b1, rx_d, rx_ok);
    chk({rx_ok, rx_d}, 10'h33c, "tx frame");
    repeat (40) @(posedge mclk);
    rd(`ASR_OFS_STAT1, 32'hc0, 32'hc0);
    chk(irq, 0, "irq gated");
    wr(`ASR_OFS_CTRL2, 32'hec);
    repeat (2) @(posedge mclk);
    chk(irq, 1, "irq enabled");
    rd(`ASR_OFS_ISTAT, 32'h1f, 32'h06);
  endtask : s_tx

  // main sequence
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    s_reset();
    s_rx();
    s_rx_err();
    s_nine();
    s_tx();
    final_report();
  end
endmodule : test_asr_serial_top
